/* rtl/eirq_regs.svh */
`ifndef EIRQ_REGS_SVH
`define EIRQ_REGS_SVH
// bit positions shared by flag and enable registers
`define EIRQ_BIT_GLOBAL 15
`define EIRQ_BIT_EXP 14
`define EIRQ_BIT_DIGEST 13
`define EIRQ_BIT_CIPHER 12
`define EIRQ_BIT_LINK 11
`define EIRQ_BIT_PEND 6
`define EIRQ_BIT_COPY 5
`define EIRQ_BIT_FIXED 4
`define EIRQ_BIT_TXDONE 3
`define EIRQ_BIT_TXABT 2
`define EIRQ_BIT_RXABT 1
`define EIRQ_BIT_CFULL 0
// reset values
`define EIRQ_FLAGS_RST 16'h0000
`define EIRQ_EN_RST 16'h8010
// bits software may write in each register
`define EIRQ_FLAGS_WMASK 16'h782f
`define EIRQ_EN_WMASK 16'hf86f
`define EIRQ_CNT_MAX 8'hff
`define EIRQ_CNT_RST 8'h00
// sources that can raise the request; bit four has no flag
`define EIRQ_REQ_MASK 16'h7fef
`endif

/* rtl/eirq_pkg.sv */
package eirq_pkg;
   typedef enum logic [1:0] {
      EIRQ_OP_NONE = 2'b00,
      EIRQ_OP_WRITE = 2'b01,
      EIRQ_OP_SET = 2'b10,
      EIRQ_OP_CLR = 2'b11
   } eirq_op_t;
endpackage

/* rtl/eirq_fall_det.sv */
`timescale 1ns/1ps
// detects a one-to-zero step of a go bit from the same clock domain
module eirq_fall_det (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic level_in,
   output logic fall_out
);
   logic prev_q;
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level_in;
      end
   end
   assign fall_out = prev_q & ~level_in;
endmodule

/* rtl/eirq_core.sv */
`timescale 1ns/1ps
`include "eirq_regs.svh"
// Contract
// - receive abort on no space or full counter
// - counter full flag when count reaches max
// - pin follows request status while globally enabled
// - enable register bits, reset with global enable and bit four set
// - enable bit four always reads one
// - no request leaves without global enable
// - exponent flag on exponent go falling
// - digest flag on block or calculation done
// - cipher flag on cipher go falling
// - link flag on any link change
// - pending flag mirrors non-zero frame count
// - copy flag on copy engine go falling
// - transmit done flag on request falling
// - transmit abort on collision, deferral, cancel
// - receive abort never for filter rejects
// - counter full clears on decrement
// - wake frame raises count, asserts request
// - flags set regardless of enables
// - pin stays low until flags cleared
// - flag register bit positions
module eirq_core (
   input wire logic mclk_in,
   input wire logic resetn_in,
   // register access port
   input wire logic [1:0] flags_op_in,
   input wire logic [1:0] en_op_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] event_flags_out,
   output logic [15:0] event_enables_out,
   output logic [15:0] global_status_out,
   // event sources
   input wire logic exp_go_in,
   input wire logic digest_done_in,
   input wire logic cipher_go_in,
   input wire logic link_up_in,
   input wire logic copy_engine_go_in,
   input wire logic tx_request_in,
   input wire logic tx_fail_in,
   input wire logic rx_no_space_in,
   input wire logic rx_frame_ok_in,
   input wire logic rx_filter_reject_in,
   input wire logic frame_dec_in,
   output logic irq_n_out
);
   logic [3:0] go_level;
   logic [3:0] go_fall;
   logic link_s1_q, link_s2_q, link_s3_q;
   logic [15:0] flags_q, flags_d, en_q, en_d, set_vec, keep_vec;
   logic [7:0] cnt_q, cnt_d;
   logic irq_n_q;
   logic req_q;
   logic req_d;

   // detectors reset low, so a go bit held high through reset gives no edge
   assign go_level = {tx_request_in, copy_engine_go_in, cipher_go_in,
      exp_go_in};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_fall
         eirq_fall_det u_fall (
            .mclk_in(mclk_in),
            .resetn_in(resetn_in),
            .level_in(go_level[gi]),
            .fall_out(go_fall[gi])
         );
      end
   endgenerate
   wire exp_fall = go_fall[0];
   wire cipher_fall = go_fall[1];
   wire copy_fall = go_fall[2];
   wire tx_fall = go_fall[3];

   // link status comes from the phy side, so it is synchronised first
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link_s1_q <= 1'b0;
         link_s2_q <= 1'b0;
         link_s3_q <= 1'b0;
      end else begin
         link_s1_q <= link_up_in;
         link_s2_q <= link_s1_q;
         link_s3_q <= link_s2_q;
      end
   end
   wire link_change = link_s2_q ^ link_s3_q;

   // frame counter; a frame arriving at max or without space is dropped
   wire cnt_full = (cnt_q == `EIRQ_CNT_MAX);
   wire frame_drop = (rx_frame_ok_in & cnt_full) | rx_no_space_in;
   // filter rejects never reach the abort flag
   wire frame_keep = rx_frame_ok_in & ~cnt_full & ~rx_no_space_in;
   wire cnt_dec = frame_dec_in & (cnt_q != 8'h00);
   always_comb begin
      cnt_d = cnt_q;
      if (frame_keep & ~cnt_dec) begin
         cnt_d = cnt_q + 8'h01;
      end else if (cnt_dec & ~frame_keep) begin
         cnt_d = cnt_q - 8'h01;
      end
   end
   wire cnt_reach_max = (cnt_d == `EIRQ_CNT_MAX) & ~cnt_full;

   // hardware sets, independent of enables
   always_comb begin
      set_vec = 16'h0000;
      set_vec[`EIRQ_BIT_EXP] = exp_fall;
      set_vec[`EIRQ_BIT_DIGEST] = digest_done_in;
      set_vec[`EIRQ_BIT_CIPHER] = cipher_fall;
      set_vec[`EIRQ_BIT_LINK] = link_change;
      set_vec[`EIRQ_BIT_COPY] = copy_fall;
      // a failed transmit is reported as abort; done still sets when the request falls
      set_vec[`EIRQ_BIT_TXDONE] = tx_fall;
      set_vec[`EIRQ_BIT_TXABT] = tx_fail_in;
      set_vec[`EIRQ_BIT_RXABT] = frame_drop;
      set_vec[`EIRQ_BIT_CFULL] = cnt_reach_max;
   end

   // a software cancel looks like a clean end from here, so the
   // transmitter reports every abort cause, cancel included, on tx_fail_in

   // shared by both registers: plain write, bit set or bit clear under mask
   function automatic logic [15:0] apply_op(input logic [1:0] op,
      input logic [15:0] cur, input logic [15:0] data,
      input logic [15:0] mask);
      logic [15:0] res;
      res = cur;
      case (eirq_pkg::eirq_op_t'(op))
         eirq_pkg::EIRQ_OP_WRITE: res = (cur & ~mask) | (data & mask);
         eirq_pkg::EIRQ_OP_SET: res = cur | (data & mask);
         eirq_pkg::EIRQ_OP_CLR: res = cur & ~(data & mask);
         default: res = cur;
      endcase
      return res;
   endfunction

   // software write path; set beats clear in the same cycle
   always_comb begin
      keep_vec = apply_op(flags_op_in, flags_q, wdata_in,
         `EIRQ_FLAGS_WMASK);
      flags_d = keep_vec | set_vec;
      // pending mirrors the counter, read only
      flags_d[`EIRQ_BIT_PEND] = (cnt_d != 8'h00);
      // counter full drops on any decrement
      if (cnt_dec) begin
         flags_d[`EIRQ_BIT_CFULL] = 1'b0;
      end
      flags_d[10:7] = 4'h0;
      flags_d[`EIRQ_BIT_FIXED] = 1'b0;
      flags_d[`EIRQ_BIT_GLOBAL] = 1'b0;
   end

   always_comb begin
      en_d = apply_op(en_op_in, en_q, wdata_in,
         `EIRQ_EN_WMASK);
      // reserved enables are held low even if software writes ones
      en_d[10:7] = 4'h0;
      en_d[`EIRQ_BIT_FIXED] = 1'b1;
   end

   // aggregated request, bit four excluded as it has no flag
   assign req_d = |(flags_d & en_d & `EIRQ_REQ_MASK);

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flags_q <= `EIRQ_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         en_q <= `EIRQ_EN_RST;
      end else begin
         en_q <= en_d;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= `EIRQ_CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // status copy kept in a flop so the output comes straight from one
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         req_q <= 1'b0;
      end else begin
         req_q <= req_d;
      end
   end

   // pin held high while global enable is low
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~(req_d & en_d[`EIRQ_BIT_GLOBAL]);
      end
   end

   assign irq_n_out = irq_n_q;
   assign event_flags_out = flags_q;
   assign event_enables_out = en_q;
   assign global_status_out = {req_q, 6'h00, link_s3_q, cnt_q};

   // request pin
   pin_gate_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      !en_q[`EIRQ_BIT_GLOBAL] |-> irq_n_out)
      else $error("request pin low while globally disabled");
   pin_follow_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      en_q[`EIRQ_BIT_GLOBAL] |-> (irq_n_out == ~req_q))
      else $error("request pin does not follow status");
   pin_hold_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (!irq_n_out && flags_op_in == 2'b00 && en_op_in == 2'b00
      && !frame_dec_in) |=> !irq_n_out)
      else $error("request pin released with no clear");
   wake_req_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (en_q[`EIRQ_BIT_GLOBAL] && en_q[`EIRQ_BIT_PEND]
      && flags_q[`EIRQ_BIT_PEND]) |-> !irq_n_out)
      else $error("pending frame did not raise request");

   // enable register
   fixed_bit_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      en_q[`EIRQ_BIT_FIXED])
      else $error("fixed enable bit lost");
   rsvd_en_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      en_q[10:7] == 4'h0)
      else $error("reserved enable bits set");
   en_write_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (en_op_in == 2'b01) |=> (en_q == (($past(wdata_in)
      & `EIRQ_EN_WMASK) | 16'h0010)))
      else $error("enable write not taken");
   en_clr_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (en_op_in == 2'b11 && wdata_in[`EIRQ_BIT_GLOBAL])
      |=> !en_q[`EIRQ_BIT_GLOBAL])
      else $error("global enable not cleared");

   // flag register
   flags_rsvd_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (flags_q[10:7] == 4'h0) && !flags_q[`EIRQ_BIT_FIXED]
      && !flags_q[`EIRQ_BIT_GLOBAL])
      else $error("reserved flag bits set");
   pend_mirror_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      flags_q[`EIRQ_BIT_PEND] == (cnt_q != 8'h00))
      else $error("pending flag does not mirror count");
   exp_set_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(exp_go_in) |=> flags_q[`EIRQ_BIT_EXP])
      else $error("exponent flag not set");
   digest_set_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      digest_done_in |=> flags_q[`EIRQ_BIT_DIGEST])
      else $error("digest flag not set");
   cipher_set_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(cipher_go_in) |=> flags_q[`EIRQ_BIT_CIPHER])
      else $error("cipher flag not set");
   link_set_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (link_s2_q != link_s3_q) |=> flags_q[`EIRQ_BIT_LINK])
      else $error("link flag not set");
   copy_set_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(copy_engine_go_in) |=> flags_q[`EIRQ_BIT_COPY])
      else $error("copy flag not set");
   tx_done_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(tx_request_in) |=> flags_q[`EIRQ_BIT_TXDONE])
      else $error("transmit done flag not set");
   tx_abort_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      tx_fail_in |=> flags_q[`EIRQ_BIT_TXABT])
      else $error("transmit abort flag not set");
   masked_set_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (tx_fail_in && !en_q[`EIRQ_BIT_TXABT]) |=> flags_q[`EIRQ_BIT_TXABT])
      else $error("disabled source flag not set");
   flag_hold_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (flags_q[`EIRQ_BIT_EXP] && flags_op_in == 2'b00)
      |=> flags_q[`EIRQ_BIT_EXP])
      else $error("latched flag cleared itself");
   flags_clr_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (flags_op_in == 2'b11 && wdata_in[`EIRQ_BIT_EXP] && !exp_fall)
      |=> !flags_q[`EIRQ_BIT_EXP])
      else $error("bit clear of flag not taken");
   set_wins_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (digest_done_in && flags_op_in == 2'b11 && wdata_in[`EIRQ_BIT_DIGEST])
      |=> flags_q[`EIRQ_BIT_DIGEST])
      else $error("clear beat a hardware set");

   // receive side and frame counter
   rx_drop_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (rx_frame_ok_in && cnt_full) |=> flags_q[`EIRQ_BIT_RXABT])
      else $error("receive abort not set on full counter");
   rx_space_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      rx_no_space_in |=> flags_q[`EIRQ_BIT_RXABT])
      else $error("receive abort not set on no space");
   cnt_sat_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (cnt_full && rx_frame_ok_in && !frame_dec_in)
      |=> (cnt_q == `EIRQ_CNT_MAX))
      else $error("frame counter wrapped");
   cfull_set_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (rx_frame_ok_in && !rx_no_space_in && !frame_dec_in
      && cnt_q == 8'hfe) |=> flags_q[`EIRQ_BIT_CFULL])
      else $error("counter full flag not set");
   cfull_clr_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (frame_dec_in && cnt_full && !rx_frame_ok_in)
      |=> !flags_q[`EIRQ_BIT_CFULL])
      else $error("counter full flag not cleared");
   reject_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (rx_filter_reject_in && !rx_frame_ok_in && !rx_no_space_in
      && !flags_q[`EIRQ_BIT_RXABT] && flags_op_in == 2'b00)
      |=> !flags_q[`EIRQ_BIT_RXABT])
      else $error("filter reject raised receive abort");
   cnt_inc_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (rx_frame_ok_in && !rx_no_space_in && !cnt_full && !frame_dec_in)
      |=> (cnt_q == $past(cnt_q) + 8'h01))
      else $error("accepted frame not counted");
   cnt_dec_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (frame_dec_in && !rx_frame_ok_in && cnt_q != 8'h00)
      |=> (cnt_q == $past(cnt_q) - 8'h01))
      else $error("frame counter not decremented");
   cnt_floor_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (frame_dec_in && !rx_frame_ok_in && cnt_q == 8'h00)
      |=> (cnt_q == 8'h00))
      else $error("frame counter went below zero");
   cnt_idle_a: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (!rx_frame_ok_in && !frame_dec_in) |=> $stable(cnt_q))
      else $error("frame counter moved with no event");
endmodule

/* bench/eirq_host_model.sv */
`timescale 1ns/1ps
// host side: only falling edges of the request wake a sleeping host
module eirq_host_model (
   input wire logic mclk_in,
   input wire logic irq_n_in,
   output int falls_out
);
   logic last_q = 1'b1;
   int falls_q = 0;
   always @(posedge mclk_in) begin
      if (last_q === 1'b1 && irq_n_in === 1'b0) begin
         falls_q <= falls_q + 1;
      end
      last_q <= irq_n_in;
   end
   assign falls_out = falls_q;
endmodule

/* bench/ethernet_event_irq_logic_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) num_checks++; if ((got) !== (ex)) begin \
   num_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end
module ethernet_event_irq_logic_tb;
   logic mclk_in, resetn_in, link_up;
   logic [1:0] flags_op, en_op;
   logic [15:0] wdata, flags, ens, stat;
   logic [9:0] ev;
   logic irq_n;
   int num_errors, num_checks, falls, f0;
   int bit_of [7] = '{14, 13, 12, 5, 3, 2, 1};
   eirq_core DUT (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .flags_op_in(flags_op), .en_op_in(en_op), .wdata_in(wdata),
      .event_flags_out(flags), .event_enables_out(ens),
      .global_status_out(stat), .exp_go_in(~ev[0]),
      .digest_done_in(ev[1]), .cipher_go_in(~ev[2]),
      .link_up_in(link_up), .copy_engine_go_in(~ev[3]),
      .tx_request_in(~ev[4]), .tx_fail_in(ev[5]),
      .rx_no_space_in(ev[6]), .rx_frame_ok_in(ev[7]),
      .rx_filter_reject_in(ev[9]), .frame_dec_in(ev[8]),
      .irq_n_out(irq_n));
   eirq_host_model HOST (.mclk_in(mclk_in), .irq_n_in(irq_n),
      .falls_out(falls));
   initial begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end
   task tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task op(input logic [1:0] f, input logic [1:0] e, input logic [15:0] d);
      @(posedge mclk_in);
      flags_op <= f;
      en_op <= e;
      wdata <= d;
      @(posedge mclk_in);
      flags_op <= 2'b00;
      en_op <= 2'b00;
      tick(1);
   endtask
   // fall detector and link sync add latency, so allow a few edges
   task pulse(input int k);
      @(posedge mclk_in);
      ev[k] <= 1'b1;
      @(posedge mclk_in);
      ev[k] <= 1'b0;
      tick(4);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end
   initial begin
      resetn_in = 1'b0;
      link_up = 1'b0;
      flags_op = 2'b00;
      en_op = 2'b00;
      wdata = 16'h0000;
      ev = 10'h000;
      repeat (12) @(posedge mclk_in);
      resetn_in <= 1'b1;
      tick(1);
      `CHK("flags", 16'h0000, flags)
      `CHK("enables", 16'h8010, ens)
      `CHK("irq", 1'b1, irq_n)
      op(2'b00, eirq_pkg::EIRQ_OP_WRITE, 16'hf86f);
      `CHK("enables", 16'hf87f, ens)
      op(2'b00, eirq_pkg::EIRQ_OP_WRITE, 16'h0000);
      `CHK("enables", 16'h0010, ens)
      for (int k = 0; k < 7; k++) begin
         pulse(k);
         `CHK("flag", 16'h0001 << bit_of[k], flags)
         `CHK("irq", 1'b1, irq_n)
         op(eirq_pkg::EIRQ_OP_CLR, 2'b00, 16'h7fff);
         `CHK("flags", 16'h0000, flags)
      end
      op(2'b00, eirq_pkg::EIRQ_OP_WRITE, 16'h8008);
      pulse(4);
      `CHK("irq", 1'b0, irq_n)
      `CHK("req", 1'b1, stat[15])
      op(2'b00, eirq_pkg::EIRQ_OP_CLR, 16'h8000);
      `CHK("irq", 1'b1, irq_n)
      op(2'b00, eirq_pkg::EIRQ_OP_SET, 16'h8000);
      `CHK("irq", 1'b0, irq_n)
      op(eirq_pkg::EIRQ_OP_CLR, 2'b00, 16'h0008);
      `CHK("irq", 1'b1, irq_n)
      op(2'b00, eirq_pkg::EIRQ_OP_WRITE, 16'h8040);
      f0 = falls;
      pulse(9);
      `CHK("flags", 16'h0000, flags)
      `CHK("count", 8'h00, stat[7:0])
      pulse(7);
      `CHK("count", 8'h01, stat[7:0])
      `CHK("flags", 16'h0040, flags)
      `CHK("wake", f0 + 1, falls)
      pulse(8);
      `CHK("flags", 16'h0000, flags)
      `CHK("irq", 1'b1, irq_n)
      repeat (255) pulse(7);
      `CHK("flags", 16'h0041, flags)
      pulse(7);
      `CHK("flags", 16'h0043, flags)
      `CHK("count", 8'hff, stat[7:0])
      pulse(8);
      `CHK("flags", 16'h0042, flags)
      `CHK("count", 8'hfe, stat[7:0])
      @(posedge mclk_in);
      link_up <= 1'b1;
      tick(6);
      `CHK("link flag", 1'b1, flags[11])
      `CHK("link state", 1'b1, stat[8])
      print_verdict();
   end
endmodule
